// File: bbc_ctrl.sv
// bus cycle condition qualifier and break control registers with apb access
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - channel B cycle qualifier is 16 bits, read/write, reset to zero
// - qualifier bits 15:8 read as zero and ignore writes
// - source field 7:6: 00 off, x1 cpu cycles, 10 dma cycles
// - access field 5:4: 00 off, 01 fetch, 10 data, 11 either
// - direction field 3:2: 00 off, 01 read, 10 write, 11 either
// - size field 1:0: 00 any size, 01 byte, 10 word, 11 longword
// - break control is 32 bits, read/write, reset to zero
// - reserved control bits 31:22 and 19:16 read zero; software writes zero
// - bit 21 set drops asid compare from channel A condition
// - bit 20 set drops asid compare from channel B condition
// - bit 15 set on channel A cpu match; only software clears by 0
// - bit 14 set on channel B cpu match; only software clears by 0
// - bit 13 set on channel A dma match; only software clears by 0
// - bit 12 set on channel B dma match; only software clears by 0
// - bit 10 picks channel A fetch break before or after execution
// - bit 7 adds data compare to channel B condition
// - bit 3 chains channels: A must match before B
// - bit 0 enables channel B execution count break
module bbc_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cyc_valid,
   input wire logic cyc_is_dma,
   input wire logic cyc_is_fetch,
   input wire logic cyc_is_write,
   input wire logic [1:0] cyc_size,
   input wire logic chan_a_cond_match,
   input wire logic chan_b_addr_match,
   input wire logic chan_b_asid_match,
   input wire logic chan_b_data_match,
   output logic chan_b_qualified,
   output logic chan_a_asid_ignore,
   output logic chan_b_asid_ignore,
   output logic trace_enable,
   output logic chan_a_fetch_break_after,
   output logic chan_b_fetch_break_after,
   output logic chan_b_data_compare_enable,
   output logic chained_channel_mode,
   output logic exec_count_break_enable,
   output logic chan_b_break_hit
);
   logic [15:0] qual_reg;
   logic [31:0] ctrl_reg;
   logic acc_phase;
   logic setup_rd;
   logic sel_qual;
   logic sel_ctrl;
   logic wr_qual;
   logic wr_ctrl;
   logic src_ok;
   logic acc_ok;
   logic dir_ok;
   logic size_ok;
   logic b_cycle_ok;
   logic b_asid_ok;
   logic b_data_ok;
   logic b_full;
   logic a_seen_reg;
   logic b_count_ok;
   logic b_hit;
   logic set_cpu_a;
   logic set_cpu_b;
   logic set_dma_a;
   logic set_dma_b;
   logic [3:0] flag_set;
   logic [3:0] flag_clr;
   logic [3:0] flag_reg;
   logic [31:0] rd_word;

   // zero wait states: every access phase is the last cycle of its transfer
   assign acc_phase = psel && penable;
   assign setup_rd = psel && !penable && !pwrite;
   // full 12-bit compare, so aliases of the two words answer as unmapped
   assign sel_qual = (paddr == bbc_pkg::QUAL_OFFSET);
   assign sel_ctrl = (paddr == bbc_pkg::CTRL_OFFSET);
   assign wr_qual = acc_phase && pwrite && sel_qual;
   assign wr_ctrl = acc_phase && pwrite && sel_ctrl;

   // each field at 00 means its compare is not performed, so it passes
   always_comb begin
      case (qual_reg[bbc_pkg::SRC_LSB +: 2])
         2'b00: begin
            src_ok = 1'b1;
         end
         2'b10: begin
            src_ok = cyc_is_dma;
         end
         default: begin
            src_ok = !cyc_is_dma;
         end
      endcase
   end

   always_comb begin
      case (qual_reg[bbc_pkg::ACC_LSB +: 2])
         2'b00: begin
            acc_ok = 1'b1;
         end
         2'b01: begin
            acc_ok = cyc_is_fetch;
         end
         2'b10: begin
            acc_ok = !cyc_is_fetch;
         end
         default: begin
            acc_ok = 1'b1;
         end
      endcase
   end

   always_comb begin
      case (qual_reg[bbc_pkg::DIR_LSB +: 2])
         2'b00: begin
            dir_ok = 1'b1;
         end
         2'b01: begin
            dir_ok = !cyc_is_write;
         end
         2'b10: begin
            dir_ok = cyc_is_write;
         end
         default: begin
            dir_ok = 1'b1;
         end
      endcase
   end

   // size code 00 is not a real access size, so it can only mean any size
   always_comb begin
      case (qual_reg[bbc_pkg::SIZE_LSB +: 2])
         2'b00: begin
            size_ok = 1'b1;
         end
         default: begin
            size_ok = (qual_reg[bbc_pkg::SIZE_LSB +: 2] == cyc_size);
         end
      endcase
   end

   assign b_cycle_ok = cyc_valid && src_ok && acc_ok && dir_ok && size_ok;
   // asid compare can be dropped; the data compare has to be asked for
   assign b_asid_ok = ctrl_reg[bbc_pkg::ASID_IGN_B_BIT] || chan_b_asid_match;
   assign b_data_ok = !ctrl_reg[bbc_pkg::DATA_CMP_B_BIT] || chan_b_data_match;
   assign b_full = b_cycle_ok && chan_b_addr_match && b_asid_ok && b_data_ok;
   // in chained mode channel B only counts once A has been seen
   assign b_count_ok = !ctrl_reg[bbc_pkg::CHAINED_BIT] || a_seen_reg;
   assign b_hit = b_full && b_count_ok;

   // channel A condition arrives already asid-qualified outside; ignore bit exported
   assign set_cpu_a = cyc_valid && !cyc_is_dma && chan_a_cond_match;
   assign set_dma_a = cyc_valid && cyc_is_dma && chan_a_cond_match;
   assign set_cpu_b = b_hit && !cyc_is_dma;
   assign set_dma_b = b_hit && cyc_is_dma;
   assign flag_set = {set_cpu_a, set_cpu_b, set_dma_a, set_dma_b};

   // an A hit in the same cycle as a B hit leaves the chain armed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_seen_reg <= 1'b0;
      end else if (!ctrl_reg[bbc_pkg::CHAINED_BIT]) begin
         a_seen_reg <= 1'b0;
      end else if (set_cpu_a || set_dma_a) begin
         a_seen_reg <= 1'b1;
      end else if (b_hit) begin
         a_seen_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qual_reg <= bbc_pkg::QUAL_RESET;
      end else if (wr_qual) begin
         qual_reg <= pwdata[15:0] & bbc_pkg::QUAL_WMASK;
      end
   end

   // match flags: one generate lane per flag bit 15..12
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_flag
         assign flag_clr[gi] = wr_ctrl && !pwdata[bbc_pkg::FLAG_DMA_B_BIT + gi];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               flag_reg[gi] <= 1'b0;
            end else if (flag_set[gi]) begin
               flag_reg[gi] <= 1'b1;
            end else if (flag_clr[gi]) begin
               flag_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // flag bits of this word are shadowed by the flag lanes on read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= bbc_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= pwdata & bbc_pkg::CTRL_WMASK;
      end
   end

   // reserved and unmapped bits come back as zero
   always_comb begin
      if (sel_qual) begin
         rd_word = {16'h0000, qual_reg};
      end else if (sel_ctrl) begin
         rd_word = {ctrl_reg[31:16], flag_reg, ctrl_reg[11:0]};
      end else begin
         rd_word = 32'h0000_0000;
      end
   end

   // captured at the setup edge and held until the next read setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata <= rd_word;
      end
   end

   // one-cycle ready pulse in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   // unmapped offsets answer with an error and never change state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && !penable && !sel_qual && !sel_ctrl;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_b_qualified <= 1'b0;
      end else begin
         chan_b_qualified <= b_cycle_ok;
      end
   end

   // registered so the break logic sees a glitch-free one-cycle hit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_b_break_hit <= 1'b0;
      end else begin
         chan_b_break_hit <= b_hit;
      end
   end

   // config bits to the asid and data comparators
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_a_asid_ignore <= 1'b0;
         chan_b_asid_ignore <= 1'b0;
         chan_b_data_compare_enable <= 1'b0;
      end else begin
         chan_a_asid_ignore <= ctrl_reg[bbc_pkg::ASID_IGN_A_BIT];
         chan_b_asid_ignore <= ctrl_reg[bbc_pkg::ASID_IGN_B_BIT];
         chan_b_data_compare_enable <= ctrl_reg[bbc_pkg::DATA_CMP_B_BIT];
      end
   end

   // config bits to break timing, counter and trace logic; one clock late
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trace_enable <= 1'b0;
         chan_a_fetch_break_after <= 1'b0;
         chan_b_fetch_break_after <= 1'b0;
         chained_channel_mode <= 1'b0;
         exec_count_break_enable <= 1'b0;
      end else begin
         trace_enable <= ctrl_reg[bbc_pkg::TRACE_EN_BIT];
         chan_a_fetch_break_after <= ctrl_reg[bbc_pkg::FETCH_AFTER_A_BIT];
         chan_b_fetch_break_after <= ctrl_reg[bbc_pkg::FETCH_AFTER_B_BIT];
         chained_channel_mode <= ctrl_reg[bbc_pkg::CHAINED_BIT];
         exec_count_break_enable <= ctrl_reg[bbc_pkg::EXEC_CNT_EN_BIT];
      end
   end
endmodule

`default_nettype wire

// File: bbc_pkg.sv
// package: register map, field positions and reset values for the bus cycle condition block
package bbc_pkg;
   localparam logic [11:0] QUAL_OFFSET = 12'h000;
   localparam logic [11:0] CTRL_OFFSET = 12'h004;
   localparam logic [15:0] QUAL_RESET = 16'h0000;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] QUAL_WMASK = 16'h00ff;
   localparam logic [31:0] CTRL_WMASK = 32'h0030_fcc9;
   localparam int SRC_LSB = 6;
   localparam int ACC_LSB = 4;
   localparam int DIR_LSB = 2;
   localparam int SIZE_LSB = 0;
   localparam int ASID_IGN_A_BIT = 21;
   localparam int ASID_IGN_B_BIT = 20;
   localparam int FLAG_CPU_A_BIT = 15;
   localparam int FLAG_CPU_B_BIT = 14;
   localparam int FLAG_DMA_A_BIT = 13;
   localparam int FLAG_DMA_B_BIT = 12;
   localparam int TRACE_EN_BIT = 11;
   localparam int FETCH_AFTER_A_BIT = 10;
   localparam int DATA_CMP_B_BIT = 7;
   localparam int FETCH_AFTER_B_BIT = 6;
   localparam int CHAINED_BIT = 3;
   localparam int EXEC_CNT_EN_BIT = 0;
   localparam logic [1:0] SIZE_BYTE = 2'b01;
   localparam logic [1:0] SIZE_WORD = 2'b10;
   localparam logic [1:0] SIZE_LONG = 2'b11;
endpackage

// File: bbc_ctrl_chk.sv
// checker: apb answer timing, read masks and channel b result causes
`timescale 1ns/10ps
`default_nettype none
module bbc_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic chan_b_addr_match,
   input wire logic chan_b_qualified,
   input wire logic chan_b_break_hit
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd;
   assign rd = pready && !pwrite;
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("late ready");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("long ready");
   property p_err; pslverr |-> pready && $past(psel && !penable); endproperty
   a_err: assert property (p_err) else $error("stray error");
   property p_qr; rd && paddr == bbc_pkg::QUAL_OFFSET |-> prdata[31:8] == '0; endproperty
   a_qr: assert property (p_qr) else $error("qualifier upper bits");
   property p_cr; rd && paddr == bbc_pkg::CTRL_OFFSET |-> !(prdata & 32'hffcf_0336); endproperty
   a_cr: assert property (p_cr) else $error("control reserved bits");
   property p_ur; pslverr && !pwrite |-> prdata == '0; endproperty
   a_ur: assert property (p_ur) else $error("unmapped read data");
   property p_hq; chan_b_break_hit |-> chan_b_qualified; endproperty
   a_hq: assert property (p_hq) else $error("hit without qualifier");
   property p_ha; chan_b_break_hit |-> $past(chan_b_addr_match); endproperty
   a_ha: assert property (p_ha) else $error("hit without address");
endmodule
bind bbc_ctrl bbc_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .chan_b_addr_match(chan_b_addr_match), .chan_b_qualified(chan_b_qualified),
   .chan_b_break_hit(chan_b_break_hit));
`default_nettype wire

// File: bbc_cyc_model.sv
// partner model: cpu or dma bus cycle source with comparator results
`timescale 1ns/10ps
`default_nettype none
module bbc_cyc_model (
   input wire logic pclk,
   input wire logic go,
   input wire logic [8:0] cmd,
   output logic valid,
   output logic [8:0] cyc
);
   initial valid = 1'b0;
   initial cyc = 9'h000;
   // idle lines toggle so a stale attribute never passes for a live one
   always @(posedge pclk) begin
      valid <= go;
      cyc <= go ? cmd : ~cyc;
   end
endmodule
`default_nettype wire

// File: bbc_ctrl_tb.sv
// testbench: register access, field decode and match flags over apb
`timescale 1ns/10ps
`default_nettype none
module bbc_ctrl_tb;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, hold = 0, arm = 0;
   logic cv, pready, pslverr, qual, hit;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rnd = 32'hf059_1269, w = '0;
   logic [8:0] cmd = '0, cyc;
   logic [7:0] q = '0, outs;
   logic [3:0] flags = '0;
   logic [32:0] rdq[$], ex;
   logic [1:0] cycq[$], cx;
   int n_mismatch = 0, total_checks = 0;
   always #12.5 pclk = ~pclk;
   bbc_cyc_model bus_model (.pclk(pclk), .go(go), .cmd(cmd), .valid(cv), .cyc(cyc));
   bbc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cyc_valid(cv), .cyc_is_dma(cyc[4]), .cyc_is_fetch(cyc[3]),
      .cyc_is_write(cyc[2]), .cyc_size(cyc[1:0]), .chan_a_cond_match(cyc[8]),
      .chan_b_addr_match(cyc[7]), .chan_b_asid_match(cyc[6]), .chan_b_data_match(cyc[5]),
      .chan_b_qualified(qual), .chan_a_asid_ignore(outs[7]), .chan_b_asid_ignore(outs[6]),
      .trace_enable(outs[5]), .chan_a_fetch_break_after(outs[4]),
      .chan_b_fetch_break_after(outs[3]), .chan_b_data_compare_enable(outs[2]),
      .chained_channel_mode(outs[1]), .exec_count_break_enable(outs[0]), .chan_b_break_hit(hit));
   function automatic logic [31:0] nx(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] e);
      if (!wr) rdq.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wctrl(input logic [31:0] d);
      w = d & 32'h0030_fcc9;
      flags &= d[15:12];
      if (!d[3]) arm = 1'b0;
      apb(1'b1, bbc_pkg::CTRL_OFFSET, d, '0);
   endtask
   task automatic cycle(input logic [8:0] c);
      logic qe, he;
      if (c[1:0] == 2'b00) c[1:0] = 2'b11;
      qe = (q[7:6] == 2'b00 || (c[4] ? q[7:6] == 2'b10 : q[6]))
         && (q[5:4] == 2'b00 || (c[3] ? q[4] : q[5]))
         && (q[3:2] == 2'b00 || (c[2] ? q[3] : q[2]))
         && (q[1:0] == 2'b00 || q[1:0] == c[1:0]);
      he = qe && c[7] && (c[6] || w[20]) && (c[5] || !w[7]) && (!w[3] || arm);
      cycq.push_back({he, qe});
      if (c[8]) flags[c[4] ? 1 : 3] = 1'b1;
      if (he) flags[c[4] ? 0 : 2] = 1'b1;
      if (he && w[3]) arm = 1'b0;
      if (c[8] && w[3]) arm = 1'b1;
      @(posedge pclk);
      cmd <= c;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         ex = rdq.pop_front();
         `CHK({pslverr, prdata}, ex)
      end
      if (hold) begin
         cx = cycq.pop_front();
         `CHK({hit, qual}, cx)
      end
      hold <= cv;
   end
   // about twenty times the cycles the sequence needs
   initial begin
      #500000;
      n_mismatch++;
      final_report();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, bbc_pkg::QUAL_OFFSET, '0, '0);
      apb(1'b0, bbc_pkg::CTRL_OFFSET, '0, '0);
      apb(1'b0, 12'h008, '0, 33'h1_0000_0000);
      $display("test reset_and_unmapped done");
      apb(1'b1, bbc_pkg::QUAL_OFFSET, 32'hffff_ffff, '0);
      apb(1'b1, 12'h00c, 32'hffff_ffff, '0);
      apb(1'b0, bbc_pkg::QUAL_OFFSET, '0, 33'h0_0000_00ff);
      wctrl(32'hffff_ffff);
      apb(1'b0, bbc_pkg::CTRL_OFFSET, '0, {1'b0, w[31:16], flags, w[11:0]});
      $display("test read_only_bits done");
      repeat (60) begin
         rnd = nx(rnd);
         q = rnd[7:0] & rnd[15:8];
         apb(1'b1, bbc_pkg::QUAL_OFFSET, {rnd[31:8], q}, '0);
         rnd = nx(rnd);
         wctrl(rnd & 32'h0030_fcc9);
         rnd = nx(rnd);
         cycle({rnd[8], 1'b0, rnd[6:0]});
         cycle({2'b01, rnd[22:16]});
         apb(1'b0, bbc_pkg::CTRL_OFFSET, '0, {1'b0, w[31:16], flags, w[11:0]});
         `CHK(outs, {w[21], w[20], w[11], w[10], w[6], w[7], w[3], w[0]})
      end
      $display("test random_cycles done");
      final_report();
   end
endmodule
`default_nettype wire
